// ==== shared/otf_pkg.sv ====
// Package for the over-temperature fault response block
`default_nettype none
package otf_pkg;
   // Register command codes
   localparam logic [7:0] REG_TRIP_THRESHOLD = 8'h4F;
   localparam logic [7:0] REG_REACTION_CFG   = 8'h50;
   localparam logic [7:0] REG_STATUS         = 8'hE0;
   // Reset values
   localparam logic [15:0] TRIP_RESET = 16'h0000;
   localparam logic [7:0]  CFG_RESET  = 8'h00;
   // Config field positions
   localparam int RESP_HI  = 7;
   localparam int RESP_LO  = 6;
   localparam int RETRY_HI = 5;
   localparam int RETRY_LO = 3;
   localparam int DELAY_HI = 2;
   localparam int DELAY_LO = 0;
   // Response codes
   localparam logic [1:0] RESP_IGNORE   = 2'h0;
   localparam logic [1:0] RESP_DELAYED  = 2'h1;
   localparam logic [1:0] RESP_DISABLE  = 2'h2;
   localparam logic [1:0] RESP_LATCHOFF = 2'h3;
   // Retry codes
   localparam logic [2:0] RETRY_NONE    = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // Delay unit counter width
   localparam int UNIT_W  = 16;
   localparam int TICKS_W = 8;

   // Decoded configuration
   typedef struct packed {
      logic [1:0] resp;
      logic [2:0] retries;
      logic [2:0] delay;
   } otf_cfg_t;

   // Register write/read bus
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] cmd;
      logic [15:0] wdata;
   } otf_req_t;
endpackage : otf_pkg
`default_nettype wire

// ==== hdl/otf_delay_timer.sv ====
// Delay timer counting 2**n units of a programmable length
`timescale 1ns/1ps
`default_nettype none
module otf_delay_timer #(
   parameter int UNIT_W = otf_pkg::UNIT_W
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              start,
   input  wire logic [2:0]        exp_sel,
   input  wire logic [UNIT_W-1:0] unit_cycles,
   output logic                   done
);
   logic [UNIT_W-1:0]          unit_cnt_r;
   logic [otf_pkg::TICKS_W:0]  units_left_r;
   logic                       run_r;

   // Unit prescaler and remaining-unit count; start restarts the timer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         unit_cnt_r   <= '0;
         units_left_r <= '0;
         run_r        <= 1'b0;
      end else if (start) begin
         unit_cnt_r   <= '0;
         units_left_r <= (otf_pkg::TICKS_W+1)'(1) << exp_sel;
         run_r        <= 1'b1;
      end else if (run_r) begin
         if (unit_cnt_r + UNIT_W'(1) >= unit_cycles) begin
            unit_cnt_r   <= '0;
            units_left_r <= units_left_r - (otf_pkg::TICKS_W+1)'(1);
            if (units_left_r == (otf_pkg::TICKS_W+1)'(1)) begin
               run_r <= 1'b0;
            end
         end else begin
            unit_cnt_r <= unit_cnt_r + UNIT_W'(1);
         end
      end
   end

   // One-cycle pulse when the last unit ends
   assign done = run_r && (unit_cnt_r + UNIT_W'(1) >= unit_cycles)
                 && (units_left_r == (otf_pkg::TICKS_W+1)'(1));
endmodule // otf_delay_timer
`default_nettype wire

// ==== hdl/otf_fault_response.sv ====
// Over-temperature fault detection and response state machine
// Behaviour
// - Holds 16-bit linear-format trip threshold
// - Response 00 keeps output running
// - Response 01 runs for delay, then retries
// - Response 10 disables at once, then retries
// - Response 11 latches off until cleared
// - Clear by bit, command, reset, off-on
// - Retry 000 means no restart
// - Retry 1..6 attempts, then stay off
// - Attempts spaced by decoded delay time
// - Retry 111 restarts until off or fault
// - Delay field decodes as two-power units
// - Delay shared; unit length from input
`timescale 1ns/1ps
`default_nettype none
module otf_fault_response #(
   parameter int UNIT_W = otf_pkg::UNIT_W
) (
   input  wire logic              CLK,
   input  wire logic              ARST_N,
   input  wire otf_pkg::otf_req_t REQ,
   output logic [15:0]            RDATA,
   input  wire logic [15:0]       TEMP,
   input  wire logic              TEMP_SIGNED,
   input  wire logic              CLEAR_FAULTS,
   input  wire logic              CLEAR_FAULT_BIT,
   input  wire logic              OUTPUT_ON_CMD,
   input  wire logic              OTHER_FAULT,
   input  wire logic [UNIT_W-1:0] DELAY_UNIT_CYCLES,
   output logic                   OUTPUT_ENABLE,
   output logic                   FAULT_FLAG,
   output logic                   TEMP_OVER
);
   typedef enum logic [5:0] {
      ST_RUN     = 6'b000001,
      ST_GRACE   = 6'b000010,
      ST_WAIT    = 6'b000100,
      ST_RETRY   = 6'b001000,
      ST_LATCHED = 6'b010000,
      ST_OFF     = 6'b100000
   } otf_state_t;

   otf_state_t        state_r, state_nxt;
   logic [15:0]       trip_r;
   otf_pkg::otf_cfg_t cfg_r;
   logic [2:0]        tries_r, tries_nxt;
   logic              fault_r;
   logic              on_cmd_q_r;
   logic              over_temp;
   logic              clear_evt;
   logic              tmr_start;
   logic              tmr_done;
   logic              retry_left;

   // Signed compare of linear values; both share one exponent here
   function automatic logic exceeds(input logic [15:0] t,
                                     input logic [15:0] lim);
      exceeds = $signed(t) > $signed(lim);
   endfunction

   assign over_temp = TEMP_SIGNED ? exceeds(TEMP, trip_r) :
                      (TEMP > trip_r);
   assign TEMP_OVER = over_temp;

   assign clear_evt = CLEAR_FAULTS || CLEAR_FAULT_BIT ||
                      (OUTPUT_ON_CMD && !on_cmd_q_r);

   assign retry_left = (cfg_r.retries == otf_pkg::RETRY_FOREVER) ||
                       (tries_r < cfg_r.retries);

   // Register writes
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         trip_r <= otf_pkg::TRIP_RESET;
         cfg_r  <= otf_pkg::CFG_RESET;
      end else if (REQ.wr) begin
         if (REQ.cmd == otf_pkg::REG_TRIP_THRESHOLD) begin
            trip_r <= REQ.wdata;
         end else if (REQ.cmd == otf_pkg::REG_REACTION_CFG) begin
            cfg_r <= REQ.wdata[7:0];
         end
      end
   end

   // Read data from flops; unknown codes read zero
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RDATA <= '0;
      end else if (REQ.rd) begin
         if (REQ.cmd == otf_pkg::REG_TRIP_THRESHOLD) begin
            RDATA <= trip_r;
         end else if (REQ.cmd == otf_pkg::REG_REACTION_CFG) begin
            RDATA <= {8'h00, cfg_r};
         end else if (REQ.cmd == otf_pkg::REG_STATUS) begin
            RDATA <= {10'h000, state_r};
         end else begin
            RDATA <= '0;
         end
      end
   end

   // Edge memory of the on command
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         on_cmd_q_r <= 1'b0;
      end else begin
         on_cmd_q_r <= OUTPUT_ON_CMD;
      end
   end

   // one timer for grace and spacing
   otf_delay_timer #(.UNIT_W(UNIT_W)) u_timer (
      .clk         (CLK),
      .arst_n      (ARST_N),
      .start       (tmr_start),
      .exp_sel     (cfg_r.delay),
      .unit_cycles (DELAY_UNIT_CYCLES),
      .done        (tmr_done)
   );

   // Response state machine
   always_comb begin
      state_nxt = state_r;
      tries_nxt = tries_r;
      tmr_start = 1'b0;
      case (state_r)
         ST_RUN: begin
            tries_nxt = '0;
            if (over_temp) begin
               case (cfg_r.resp)
                  otf_pkg::RESP_IGNORE: state_nxt = ST_RUN;
                  otf_pkg::RESP_DELAYED: begin
                     state_nxt = ST_GRACE;
                     tmr_start = 1'b1;
                  end
                  otf_pkg::RESP_DISABLE: begin
                     state_nxt = (cfg_r.retries == otf_pkg::RETRY_NONE)
                                 ? ST_LATCHED : ST_WAIT;
                     tmr_start = 1'b1;
                  end
                  default: state_nxt = ST_LATCHED;
               endcase
            end
         end
         ST_GRACE: begin
            if (!over_temp) begin
               state_nxt = ST_RUN;
            end else if (tmr_done) begin
               if (cfg_r.retries == otf_pkg::RETRY_NONE) begin
                  state_nxt = ST_LATCHED;
               end else begin
                  state_nxt = ST_WAIT;
                  tmr_start = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            if (tmr_done) begin
               if (retry_left) begin
                  state_nxt = ST_RETRY;
                  tries_nxt = tries_r + 3'h1;
               end else begin
                  state_nxt = ST_LATCHED;
               end
            end
         end
         ST_RETRY: begin
            // Restart attempt: fails if still hot
            if (over_temp) begin
               state_nxt = retry_left ? ST_WAIT : ST_LATCHED;
               tmr_start = retry_left;
            end else begin
               state_nxt = ST_RUN;
            end
         end
         ST_LATCHED: state_nxt = ST_LATCHED;
         default: state_nxt = ST_OFF;
      endcase
      // other fault or off command stops
      if (OTHER_FAULT || !OUTPUT_ON_CMD) begin
         state_nxt = ST_OFF;
      end
      if (clear_evt && (state_r == ST_LATCHED || state_r == ST_OFF ||
                        state_r == ST_WAIT || state_r == ST_RETRY)) begin
         state_nxt = (OUTPUT_ON_CMD && !OTHER_FAULT) ? ST_RUN : ST_OFF;
      end
      if (state_r == ST_OFF && OUTPUT_ON_CMD && !OTHER_FAULT &&
          on_cmd_q_r) begin
         state_nxt = ST_OFF;
      end
   end

   // State and attempt counter
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= ST_OFF;
         tries_r <= '0;
      end else begin
         state_r <= state_nxt;
         tries_r <= (state_nxt == ST_RUN) ? 3'h0 : tries_nxt;
      end
   end

   // Output enable and sticky fault flag; set wins over clear
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         OUTPUT_ENABLE <= 1'b0;
         fault_r       <= 1'b0;
      end else begin
         OUTPUT_ENABLE <= (state_nxt == ST_RUN) ||
                          (state_nxt == ST_GRACE) ||
                          (state_nxt == ST_RETRY);
         if (over_temp && cfg_r.resp != otf_pkg::RESP_IGNORE) begin
            fault_r <= 1'b1;
         end else if (clear_evt) begin
            fault_r <= 1'b0;
         end
      end
   end
   assign FAULT_FLAG = fault_r;

   // Checks share the state clock; reset masks them
   // Hot in run under one response, no off command or other fault
   sequence hot_run_s(logic [1:0] r);
      state_r == ST_RUN && over_temp && cfg_r.resp == r &&
      OUTPUT_ON_CMD && !OTHER_FAULT;
   endsequence

   // Final attempt failed while still hot and nothing clears it
   sequence spent_retry_s;
      state_r == ST_RETRY && over_temp && !retry_left &&
      OUTPUT_ON_CMD && !OTHER_FAULT && !clear_evt;
   endsequence

   latched_off_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      state_r == ST_LATCHED && !clear_evt |=> !OUTPUT_ENABLE)
      else $error("output on while latched");

   disable_now_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      hot_run_s(otf_pkg::RESP_DISABLE) |=> !OUTPUT_ENABLE)
      else $error("no immediate disable");

   ignore_run_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      state_r == ST_RUN && cfg_r.resp == otf_pkg::RESP_IGNORE &&
      OUTPUT_ON_CMD && !OTHER_FAULT && !clear_evt |=> state_r == ST_RUN)
      else $error("ignore left run");

   off_cmd_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      !OUTPUT_ON_CMD |=> state_r == ST_OFF && !OUTPUT_ENABLE)
      else $error("not off on command");

   other_fault_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      OTHER_FAULT |=> state_r == ST_OFF && !OUTPUT_ENABLE)
      else $error("not off on other fault");

   grace_run_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      hot_run_s(otf_pkg::RESP_DELAYED) |=> state_r == ST_GRACE &&
      OUTPUT_ENABLE)
      else $error("grace not entered with output on");

   grace_latch_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      state_r == ST_GRACE && over_temp && tmr_done &&
      cfg_r.retries == otf_pkg::RETRY_NONE && OUTPUT_ON_CMD &&
      !OTHER_FAULT |=> state_r == ST_LATCHED && !OUTPUT_ENABLE)
      else $error("grace end did not latch");

   wait_hold_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      state_r == ST_WAIT && !tmr_done && OUTPUT_ON_CMD && !OTHER_FAULT &&
      !clear_evt |=> state_r == ST_WAIT && !OUTPUT_ENABLE)
      else $error("attempt before delay ended");

   retries_spent_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      spent_retry_s |=> state_r == ST_LATCHED && !OUTPUT_ENABLE)
      else $error("did not latch after last attempt");

   clear_run_a: assert property (@(posedge CLK)
      disable iff (!ARST_N)
      state_r == ST_LATCHED && clear_evt && OUTPUT_ON_CMD &&
      !OTHER_FAULT |=> state_r == ST_RUN && OUTPUT_ENABLE)
      else $error("clear did not restart");
endmodule // otf_fault_response
`default_nettype wire

// ==== verif/otf_host_model.sv ====
// Host-side model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module otf_host_model (
   input  wire logic        CLK,
   input  wire logic [15:0] RDATA,
   output var otf_pkg::otf_req_t REQ
);
   // Bus idle at time zero
   initial begin
      REQ = '0;
   end

   // One request; idle fields inverted so stale values never pass
   task automatic xfer(input logic w, input logic [7:0] c,
                       input logic [15:0] d, output logic [15:0] q);
      @(negedge CLK);
      REQ.wr = w;
      REQ.rd = !w;
      REQ.cmd = c;
      REQ.wdata = d;
      @(negedge CLK);
      REQ.wr = 1'b0;
      REQ.rd = 1'b0;
      REQ.cmd = ~c;
      REQ.wdata = ~d;
      @(negedge CLK); // Read data settled by now
      q = RDATA;
   endtask
endmodule // otf_host_model
`default_nettype wire

// ==== verif/over_temp_fault_response_test.sv ====
// Testbench for the over-temperature fault response block
`timescale 1ns/1ps
`default_nettype none
module over_temp_fault_response_test;
   logic clk, arst_n, tsig, clr_all, clr_bit, on_cmd, oth;
   logic [15:0] temp, rdata, q, unit_len;
   logic oe, flag, over;
   otf_pkg::otf_req_t req;
   int mismatches, checked, cycles, rises, gap;

   otf_host_model otf_host_model_i (.CLK(clk), .RDATA(rdata), .REQ(req));
   otf_fault_response #(.UNIT_W(16)) otf_fault_response_i (
      .CLK(clk), .ARST_N(arst_n), .REQ(req), .RDATA(rdata), .TEMP(temp),
      .TEMP_SIGNED(tsig), .CLEAR_FAULTS(clr_all), .CLEAR_FAULT_BIT(clr_bit),
      .OUTPUT_ON_CMD(on_cmd), .OTHER_FAULT(oth),
      .DELAY_UNIT_CYCLES(unit_len), .OUTPUT_ENABLE(oe),
      .FAULT_FLAG(flag), .TEMP_OVER(over));

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      otf_host_model_i.xfer(1'b1, c, d, q);
   endtask

   // Count enable rises over n cycles and the shortest spacing
   task automatic watch(input int n);
      int last;
      logic prev;
      last = -1000;
      prev = oe;
      rises = 0;
      gap = 1000;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         if (oe === 1'b1 && prev !== 1'b1) begin
            rises++;
            if (i - last < gap) gap = i - last;
            last = i;
         end
         prev = oe;
      end
   endtask

   task automatic pulse_clear(input logic all);
      @(negedge clk);
      if (all) clr_all = 1'b1; else clr_bit = 1'b1;
      @(negedge clk);
      clr_all = 1'b0;
      clr_bit = 1'b0;
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Main sequence
   initial begin
      {arst_n, tsig, clr_all, clr_bit, on_cmd, oth} = '0;
      temp = 16'h0050;
      unit_len = 16'h0002;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      otf_host_model_i.xfer(1'b0, 8'h4F, 16'h0000, q);
      chk(q, otf_pkg::TRIP_RESET);
      otf_host_model_i.xfer(1'b0, 8'h50, 16'h0000, q);
      chk(q, {8'h00, otf_pkg::CFG_RESET});
      wr(8'h4F, 16'hA5C3);
      wr(8'h50, 16'h00A5);
      otf_host_model_i.xfer(1'b0, 8'h4F, 16'h0000, q);
      chk(q, 16'hA5C3);
      otf_host_model_i.xfer(1'b0, 8'h50, 16'h0000, q);
      chk(q, 16'h00A5);
      otf_host_model_i.xfer(1'b0, 8'h3C, 16'h0000, q);
      chk(q, 16'h0000);
      wr(8'h4F, 16'h0100);
      wr(8'h50, 16'h0000);
      on_cmd = 1'b1;
      watch(4);
      chk(oe, 1'b1);
      $display("test registers done");
      // Ignore response keeps running while hot
      temp = 16'h0200;
      watch(40);
      chk(over, 1'b1);
      chk(16'(rises), 16'h0000);
      chk(oe, 1'b1);
      // Signed compare: negative reading stays below threshold
      tsig = 1'b1;
      temp = 16'hFF00;
      @(negedge clk);
      chk(over, 1'b0);
      tsig = 1'b0;
      @(negedge clk);
      chk(over, 1'b1);
      $display("test ignore done");
      // Latch off, then clear by command
      wr(8'h50, 16'h00C0);
      watch(60);
      chk(oe, 1'b0);
      chk(16'(rises), 16'h0000);
      chk(flag, 1'b1);
      temp = 16'h0050;
      pulse_clear(1'b1);
      watch(4);
      chk(oe, 1'b1);
      chk(flag, 1'b0);
      $display("test latch done");
      // Disable and retry twice, eight-cycle spacing
      wr(8'h50, 16'h0092);
      temp = 16'h0200;
      watch(300);
      chk(16'(rises), 16'h0002);
      chk(16'(gap >= 8), 16'h0001);
      chk(oe, 1'b0);
      temp = 16'h0050;
      on_cmd = 1'b0;
      watch(3);
      on_cmd = 1'b1;
      watch(4);
      chk(oe, 1'b1);
      $display("test retry done");
      // Grace period then no retry
      wr(8'h50, 16'h0042);
      temp = 16'h0200;
      watch(3);
      chk(oe, 1'b1);
      watch(100);
      chk(oe, 1'b0);
      chk(16'(rises), 16'h0000);
      temp = 16'h0050;
      pulse_clear(1'b0);
      watch(4);
      chk(oe, 1'b1);
      $display("test grace done");
      // Endless retry until another fault, three-cycle unit
      unit_len = 16'h0003;
      wr(8'h50, 16'h00B9);
      temp = 16'h0200;
      watch(300);
      chk(16'(rises > 6), 16'h0001);
      chk(16'(gap >= 6), 16'h0001);
      oth = 1'b1;
      watch(100);
      chk(16'(rises), 16'h0000);
      chk(oe, 1'b0);
      $display("test endless done");
      // Mid-run reset clears the fault and the registers
      chk(flag, 1'b1);
      arst_n = 1'b0;
      @(negedge clk);
      chk(flag, 1'b0);
      chk(oe, 1'b0);
      arst_n = 1'b1;
      otf_host_model_i.xfer(1'b0, 8'h50, 16'h0000, q);
      chk(q, {8'h00, otf_pkg::CFG_RESET});
      $display("test reset done");
      end_sim();
   end
endmodule // over_temp_fault_response_test
`default_nettype wire
